// File: vss_far_model.sv
`timescale 1ns/100ps
// Processor code source plus the gate drivers' view of the pins
module vss_far_model #(
    parameter int STEP_CYC = 40
) (
    input wire logic clk_sys,
    input wire logic [7:0] target,
    input wire logic jump,
    output logic [7:0] voltage_code,
    input wire logic [5:0] pwm_o,
    input wire logic [5:0] pwm_oe,
    output logic [5:0] low_fet_on
);
    int cnt;
    // Jump only on command; otherwise one code per interval, never more
    always_ff @(posedge clk_sys) begin
        cnt <= (jump || cnt == STEP_CYC) ? 0 : cnt + 1;
        if (jump) begin
            voltage_code <= target;
        end else if (cnt == STEP_CYC && voltage_code < target) begin
            voltage_code <= voltage_code + 8'h01;
        end else if (cnt == STEP_CYC && voltage_code > target) begin
            voltage_code <= voltage_code - 8'h01;
        end
    end
    // Lower switch is on only while the pin is driven low
    assign low_fet_on = pwm_oe & ~pwm_o;
endmodule

// File: vss_pkg.sv
package vss_pkg;
    // Clock and timing base
    localparam int CLK_KHZ = 40000;
    localparam int CYC_PER_US = CLK_KHZ / 1000;
    localparam int INIT_DELAY_US = 1360;
    localparam int INIT_DELAY_CYC = INIT_DELAY_US * CYC_PER_US;
    localparam int BOOT_HOLD_US = 85;
    localparam int BOOT_HOLD_CYC = BOOT_HOLD_US * CYC_PER_US;
    localparam int VALID_NS = 500;
    localparam int VALID_CYC = (VALID_NS * CLK_KHZ + 999999) / 1000000;
    localparam int READY_DELAY_US = 85;
    localparam int READY_DELAY_CYC = READY_DELAY_US * CYC_PER_US;

    // Switching cycle and code sampling
    localparam int FSW_KHZ = 500;
    localparam int SW_CYCLE_CYC = CLK_KHZ / FSW_KHZ;
    localparam int SAMPLES_PER_CYCLE = 6;

    // Soft-start oscillator: period in us is rate kohm / divisor
    localparam int SS_KOHM_DIV = 25;
    localparam logic [9:0] SS_RATE_RST = 10'h064;

    // DAC levels in 6.25mV units
    localparam logic [9:0] CODE_BASE = 10'h102;
    localparam logic [8:0] BOOT_LEVEL = 9'h0B0;
    localparam logic [8:0] DYN_STEP = 9'h002;
    localparam logic [8:0] SS_STEP = 9'h001;

    // Register map (byte addresses)
    localparam logic [7:0] SS_RATE_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] LEVEL_OFF = 8'h08;

    // Status field positions
    localparam int ST_READY_BIT = 3;
    localparam int ST_OVL_BIT = 4;
    localparam int ST_OVD_BIT = 5;
    localparam int ST_UV_BIT = 6;
    localparam int ST_TRIP_BIT = 7;
    localparam int ST_EN_BIT = 8;
    localparam int LV_CODE_LSB = 16;

    typedef enum logic [2:0] {
        VSS_SHUT,
        VSS_DELAY,
        VSS_RAMP1,
        VSS_HOLD,
        VSS_VALID,
        VSS_RAMP2,
        VSS_RUN,
        VSS_OFF
    } vss_state_t;
endpackage

// File: vss_sequencer.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// [RULE1] Sample voltage code six times per switching cycle
// [RULE2] On change, wait half cycle, step 12.5mV
// [RULE3] Drop pending step if difference changes meanwhile
// [RULE4] Large gap: 12.5mV steps six times per cycle
// [RULE5] Processor should step code one at a time
// [RULE6] Shutdown keeps all PWM outputs high impedance (an overvoltage still drives them low here)
// [RULE7] Leave shutdown only with POR and enables
// [RULE8] Power enable comparator has about 130mV hysteresis
// [RULE9] Delay, ramp to 1.1V boot, then hold
// [RULE10] Hold 85us plus 500ns code validation
// [RULE11] Valid code ramps on; off code shuts down
// [RULE12] Soft-start ramps move 6.25mV per oscillator period
// [RULE13] Step period is rate kohm over 25 us
// [RULE14] Ready rises after soft-start plus 85us
// [RULE15] Ready low on faults, disable, off code
// [RULE16] Undervoltage below 50%, recovery at 60%
// [RULE17] Overvoltage trip: boot level, then code based
// [RULE18] Overvoltage drives PWM low until sense drops
// [RULE19] Recurring overvoltage repeats the low drive
// [RULE20] Overvoltage latches PWM off until enable cycled
// [RULE21] Comparator flags synchronised before use
module vss_sequencer #(
    parameter int NPHASE = 6,
    parameter int INIT_DELAY_CYC = vss_pkg::INIT_DELAY_CYC,
    parameter int SW_CYCLE_CYC = vss_pkg::SW_CYCLE_CYC
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] voltage_code,
    input wire logic por_ok_in,
    input wire logic power_enable_in,
    input wire logic term_rail_enable_in,
    input wire logic uv_below_in,
    input wire logic uv_recover_in,
    input wire logic ov_trip_in,
    input wire logic diff_below_in,
    input wire logic [NPHASE-1:0] pwm_in,
    output logic [NPHASE-1:0] pwm_o,
    output logic [NPHASE-1:0] pwm_oe,
    output logic [8:0] dac_level,
    output logic ov_code_trip_sel,
    output logic regulator_ready_o,
    output logic regulator_ready_oe
);
    localparam int SMP_CYC = SW_CYCLE_CYC / vss_pkg::SAMPLES_PER_CYCLE;
    localparam int HALF_CYC = SW_CYCLE_CYC / 2;

    vss_pkg::vss_state_t state_reg;
    logic [19:0] seq_cnt_reg;
    logic [6:0] sync1_reg, sync2_reg, flag_raw;
    logic por_s, pwr_s, vtt_s, uvb_s, uvr_s, ov_s, dlow_s;
    logic enabled, ov_hit;
    logic [7:0] code_smp_reg, code_prev_reg, boot_code_reg;
    logic [15:0] smp_cnt_reg, half_cnt_reg;
    logic smp_tick, chg_reg;
    logic [9:0] ss_rate_reg;
    logic [19:0] ss_acc_reg, ss_lim, ss_sum;
    logic ramping, ss_tick;
    logic [8:0] dac_reg, tgt, dmag;
    logic signed [10:0] diff, pend_diff_reg;
    logic pend_reg;
    logic ovd_reg, ovl_reg, uv_low_reg, normal;
    logic [31:0] rd_data;
    logic rd_hit;

    // Off codes force shutdown instead of a level
    function automatic logic code_is_off(input logic [7:0] c);
        return c == 8'h00 || c == 8'h01 || c == 8'hFE || c == 8'hFF;
    endfunction

    function automatic logic [8:0] code_level(input logic [7:0] c);
        logic [9:0] t;
        t = vss_pkg::CODE_BASE - {2'b00, c};
        return code_is_off(c) ? 9'h000 : t[8:0];
    endfunction

    // Clamped move toward the target, never overshoots
    function automatic logic [8:0] step_toward(
        input logic [8:0] lvl,
        input logic signed [10:0] d,
        input logic [8:0] maxs
    );
        logic [10:0] neg;
        logic [8:0] mag;
        neg = -d;
        mag = d[10] ? neg[8:0] : d[8:0];
        if (mag > maxs) begin
            mag = maxs;
        end
        return d[10] ? lvl - mag : lvl + mag;
    endfunction

    // Two-stage sync of the analog comparator flags
    assign flag_raw = {diff_below_in, ov_trip_in, uv_recover_in,
                       uv_below_in, term_rail_enable_in,
                       power_enable_in, por_ok_in};
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            sync1_reg <= 7'h00;
            sync2_reg <= 7'h00;
        end else begin
            sync1_reg <= flag_raw; // RULE21
            sync2_reg <= sync1_reg;
        end
    end
    assign {dlow_s, ov_s, uvr_s, uvb_s, vtt_s, pwr_s, por_s} = sync2_reg;

    // Hysteresis lives in the comparator; logic sees a clean level
    assign enabled = por_s & pwr_s & vtt_s; // RULE7 RULE8
    assign ov_hit = ov_s & por_s; // RULE17

    // Code sample tick, six per switching cycle
    always_ff @(posedge clk_sys) begin
        if (reset || smp_tick) begin
            smp_cnt_reg <= 16'h0000;
        end else begin
            smp_cnt_reg <= smp_cnt_reg + 16'h0001;
        end
    end
    assign smp_tick = smp_cnt_reg == 16'(SMP_CYC - 1);

    // Sampled code and change detect
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            code_smp_reg <= 8'hFF;
            chg_reg <= 1'b0;
            code_prev_reg <= 8'hFF;
        end else begin
            code_prev_reg <= voltage_code;
            chg_reg <= smp_tick && voltage_code != code_smp_reg;
            if (smp_tick) begin
                code_smp_reg <= voltage_code; // RULE1
            end
        end
    end

    // Soft-start oscillator: fractional accumulator keeps rate exact
    assign ramping = state_reg == vss_pkg::VSS_RAMP1 ||
                     state_reg == vss_pkg::VSS_RAMP2;
    assign ss_lim = 20'(ss_rate_reg) * 20'(vss_pkg::CYC_PER_US);
    assign ss_sum = ss_acc_reg + 20'(vss_pkg::SS_KOHM_DIV);
    assign ss_tick = ramping && ss_sum >= ss_lim; // RULE13
    always_ff @(posedge clk_sys) begin
        if (reset || !ramping) begin
            ss_acc_reg <= 20'h00000;
        end else if (ss_tick) begin
            ss_acc_reg <= ss_sum - ss_lim;
        end else begin
            ss_acc_reg <= ss_sum;
        end
    end

    // Startup sequencer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= vss_pkg::VSS_SHUT;
            seq_cnt_reg <= 20'h00000;
            boot_code_reg <= 8'hFF;
        end else if (!enabled) begin
            state_reg <= vss_pkg::VSS_SHUT; // RULE7 RULE15
            seq_cnt_reg <= 20'h00000;
        end else begin
            unique case (state_reg)
                vss_pkg::VSS_SHUT: begin
                    state_reg <= vss_pkg::VSS_DELAY;
                    seq_cnt_reg <= 20'h00000;
                end
                vss_pkg::VSS_DELAY: begin
                    if (seq_cnt_reg == 20'(INIT_DELAY_CYC - 1)) begin
                        state_reg <= vss_pkg::VSS_RAMP1; // RULE9
                        seq_cnt_reg <= 20'h00000;
                    end else begin
                        seq_cnt_reg <= seq_cnt_reg + 20'h00001;
                    end
                end
                vss_pkg::VSS_RAMP1: begin
                    if (dac_reg == vss_pkg::BOOT_LEVEL) begin
                        state_reg <= vss_pkg::VSS_HOLD; // RULE9
                        seq_cnt_reg <= 20'h00000;
                    end
                end
                vss_pkg::VSS_HOLD: begin
                    if (seq_cnt_reg ==
                        20'(vss_pkg::BOOT_HOLD_CYC - 1)) begin
                        state_reg <= vss_pkg::VSS_VALID; // RULE10
                        seq_cnt_reg <= 20'h00000;
                    end else begin
                        seq_cnt_reg <= seq_cnt_reg + 20'h00001;
                    end
                end
                vss_pkg::VSS_VALID: begin
                    // Code must stand still for the whole window
                    if (voltage_code != code_prev_reg) begin
                        seq_cnt_reg <= 20'h00000; // RULE10
                    end else if (seq_cnt_reg ==
                                 20'(vss_pkg::VALID_CYC - 1)) begin
                        boot_code_reg <= voltage_code;
                        seq_cnt_reg <= 20'h00000;
                        if (code_is_off(voltage_code)) begin
                            state_reg <= vss_pkg::VSS_OFF; // RULE11
                        end else begin
                            state_reg <= vss_pkg::VSS_RAMP2; // RULE11
                        end
                    end else begin
                        seq_cnt_reg <= seq_cnt_reg + 20'h00001;
                    end
                end
                vss_pkg::VSS_RAMP2: begin
                    if (dac_reg == tgt) begin
                        state_reg <= vss_pkg::VSS_RUN;
                        seq_cnt_reg <= 20'h00000;
                    end
                end
                vss_pkg::VSS_RUN: begin
                    if (code_is_off(code_smp_reg)) begin
                        state_reg <= vss_pkg::VSS_OFF; // RULE15
                    end else if (seq_cnt_reg !=
                                 20'(vss_pkg::READY_DELAY_CYC)) begin
                        seq_cnt_reg <= seq_cnt_reg + 20'h00001;
                    end
                end
                vss_pkg::VSS_OFF: begin
                    // Only an enable or POR drop gets out of here
                    state_reg <= vss_pkg::VSS_OFF; // RULE11
                end
            endcase
        end
    end

    // Target and distance to it
    assign tgt = state_reg == vss_pkg::VSS_RAMP2 ?
                 code_level(boot_code_reg) : code_level(code_smp_reg);
    assign diff = $signed({2'b00, tgt}) - $signed({2'b00, dac_reg});
    assign dmag = diff[10] ? 9'(-diff) : diff[8:0];

    // DAC level: soft-start ramps and on-the-fly code tracking
    always_ff @(posedge clk_sys) begin
        if (reset || state_reg == vss_pkg::VSS_SHUT ||
            state_reg == vss_pkg::VSS_OFF) begin
            dac_reg <= 9'h000;
            pend_reg <= 1'b0;
            pend_diff_reg <= 11'sh000;
            half_cnt_reg <= 16'h0000;
        end else if (state_reg == vss_pkg::VSS_RAMP1) begin
            if (ss_tick && dac_reg != vss_pkg::BOOT_LEVEL) begin
                dac_reg <= dac_reg + vss_pkg::SS_STEP; // RULE12
            end
        end else if (state_reg == vss_pkg::VSS_RAMP2) begin
            if (ss_tick && diff != 11'sh000) begin
                dac_reg <= step_toward(dac_reg, diff,
                                       vss_pkg::SS_STEP); // RULE12
            end
        end else if (state_reg == vss_pkg::VSS_RUN) begin
            if (pend_reg) begin
                if (diff != pend_diff_reg) begin
                    pend_reg <= 1'b0; // RULE3
                end else if (half_cnt_reg == 16'h0000) begin
                    pend_reg <= 1'b0;
                    dac_reg <= step_toward(dac_reg, diff,
                                           vss_pkg::DYN_STEP); // RULE2
                end else begin
                    half_cnt_reg <= half_cnt_reg - 16'h0001;
                end
            end else if (smp_tick && dmag != 9'h000) begin
                // Leftover gap closes each tick; CPU should avoid jumps
                dac_reg <= step_toward(dac_reg, diff,
                                       vss_pkg::DYN_STEP); // RULE4 RULE5
            end else if (chg_reg && diff != 11'sh000) begin
                pend_reg <= 1'b1; // RULE2
                pend_diff_reg <= diff;
                half_cnt_reg <= 16'(HALF_CYC - 1);
            end
        end
    end

    // Overvoltage: low drive until sense drops, then high-Z
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ovd_reg <= 1'b0;
        end else if (ov_hit) begin
            ovd_reg <= 1'b1; // RULE18 RULE19
        end else if (dlow_s) begin
            ovd_reg <= 1'b0; // RULE18
        end
    end

    // Latch-off survives code changes; set beats clear
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ovl_reg <= 1'b0;
        end else if (ov_hit) begin
            ovl_reg <= 1'b1; // RULE20
        end else if (!enabled) begin
            ovl_reg <= 1'b0; // RULE20
        end
    end

    // Undervoltage with 50/60 percent hysteresis
    always_ff @(posedge clk_sys) begin
        if (reset || state_reg != vss_pkg::VSS_RUN) begin
            uv_low_reg <= 1'b0;
        end else if (uvb_s) begin
            uv_low_reg <= 1'b1; // RULE16
        end else if (uvr_s) begin
            uv_low_reg <= 1'b0; // RULE16
        end
    end

    // PWM pins: one flop of latency is the price of clean outputs
    assign normal = enabled && !ovl_reg &&
                    state_reg != vss_pkg::VSS_SHUT &&
                    state_reg != vss_pkg::VSS_DELAY &&
                    state_reg != vss_pkg::VSS_OFF;
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pwm_o <= '0;
            pwm_oe <= '0;
        end else if (ovd_reg) begin
            pwm_o <= '0; // RULE18 RULE19
            pwm_oe <= '1;
        end else if (normal) begin
            pwm_o <= pwm_in;
            pwm_oe <= '1;
        end else begin
            pwm_o <= '0; // RULE6
            pwm_oe <= '0;
        end
    end

    // Ready pin, open drain; enable pulls it low
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regulator_ready_o <= 1'b0;
            regulator_ready_oe <= 1'b1;
        end else begin
            regulator_ready_o <= 1'b0;
            regulator_ready_oe <= !(enabled && !uv_low_reg &&
                !ovl_reg && !ovd_reg &&
                state_reg == vss_pkg::VSS_RUN &&
                seq_cnt_reg == 20'(vss_pkg::READY_DELAY_CYC)); // RULE14 RULE15
        end
    end

    // Analog-facing outputs
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            dac_level <= 9'h000;
            ov_code_trip_sel <= 1'b0;
        end else begin
            dac_level <= dac_reg;
            ov_code_trip_sel <= state_reg == vss_pkg::VSS_RAMP2 ||
                                state_reg == vss_pkg::VSS_RUN; // RULE17
        end
    end

    // Register read decode
    always_comb begin
        rd_data = 32'h00000000;
        rd_hit = paddr[1:0] == 2'b00;
        unique case (paddr)
            vss_pkg::SS_RATE_OFF: rd_data[9:0] = ss_rate_reg;
            vss_pkg::STATUS_OFF: begin
                rd_data[2:0] = state_reg;
                rd_data[vss_pkg::ST_READY_BIT] = !regulator_ready_oe;
                rd_data[vss_pkg::ST_OVL_BIT] = ovl_reg;
                rd_data[vss_pkg::ST_OVD_BIT] = ovd_reg;
                rd_data[vss_pkg::ST_UV_BIT] = uv_low_reg;
                rd_data[vss_pkg::ST_TRIP_BIT] = ov_code_trip_sel;
                rd_data[vss_pkg::ST_EN_BIT] = enabled;
            end
            vss_pkg::LEVEL_OFF: begin
                rd_data[8:0] = dac_reg;
                rd_data[vss_pkg::LV_CODE_LSB +: 8] = code_smp_reg;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // APB answer: ready in the first access cycle
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= psel && !penable;
            if (psel && !penable) begin
                pslverr <= !rd_hit;
                prdata <= pwrite ? 32'h00000000 : rd_data;
            end
        end
    end

    // Soft-start rate register, in kohm
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ss_rate_reg <= vss_pkg::SS_RATE_RST;
        end else if (psel && penable && pready && pwrite &&
                     paddr == vss_pkg::SS_RATE_OFF) begin
            ss_rate_reg <= pwdata[9:0]; // RULE13
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    property p_hiz_shut;
        state_reg == vss_pkg::VSS_SHUT && !ovd_reg |=> pwm_oe == '0;
    endproperty
    a_hiz_shut: assert property (p_hiz_shut) // RULE6
        else $error("PWM driven during shutdown");

    property p_stay_shut;
        state_reg == vss_pkg::VSS_SHUT && !enabled
            |=> state_reg == vss_pkg::VSS_SHUT;
    endproperty
    a_stay_shut: assert property (p_stay_shut) // RULE7
        else $error("Left shutdown while not enabled");

    property p_ov_low;
        ov_hit |-> ##2 (&pwm_oe && pwm_o == '0);
    endproperty
    a_ov_low: assert property (p_ov_low) // RULE18
        else $error("PWM not driven low on overvoltage");

    property p_ov_latch;
        ovl_reg && enabled |=> ovl_reg;
    endproperty
    a_ov_latch: assert property (p_ov_latch) // RULE20
        else $error("Overvoltage latch dropped while enabled");

    property p_ready_path;
        !regulator_ready_oe |-> $past(state_reg) == vss_pkg::VSS_RUN &&
            $past(seq_cnt_reg) == 20'(vss_pkg::READY_DELAY_CYC);
    endproperty
    a_ready_path: assert property (p_ready_path) // RULE14
        else $error("Ready released too early");

    property p_ready_fault;
        uv_low_reg || ovl_reg || !enabled |=> regulator_ready_oe;
    endproperty
    a_ready_fault: assert property (p_ready_fault) // RULE15
        else $error("Ready high during fault or disable");

    property p_abandon;
        state_reg == vss_pkg::VSS_RUN && pend_reg &&
            diff != pend_diff_reg |=> !pend_reg && $stable(dac_reg);
    endproperty
    a_abandon: assert property (p_abandon) // RULE3
        else $error("Pending step not abandoned");

    property p_dyn_step;
        state_reg == vss_pkg::VSS_RUN && enabled && pend_reg &&
            half_cnt_reg == 16'h0000 && diff == pend_diff_reg
            |=> dac_reg != $past(dac_reg);
    endproperty
    a_dyn_step: assert property (p_dyn_step) // RULE2
        else $error("No DAC step after half-cycle wait");

    property p_ramp1_step;
        state_reg == vss_pkg::VSS_RAMP1 && enabled && ss_tick &&
            dac_reg != vss_pkg::BOOT_LEVEL
            |=> dac_reg == $past(dac_reg) + 9'h001;
    endproperty
    a_ramp1_step: assert property (p_ramp1_step) // RULE12
        else $error("Ramp step not one LSB");

    property p_valid_wait;
        $rose(state_reg == vss_pkg::VSS_RAMP2)
            |-> $past(seq_cnt_reg) == 20'(vss_pkg::VALID_CYC - 1);
    endproperty
    a_valid_wait: assert property (p_valid_wait) // RULE10
        else $error("Second ramp without full validation");
endmodule

// File: vss_sequencer_tb_top.sv
`timescale 1ns/100ps
module vss_sequencer_tb_top;
    logic clk_sys, reset, psel, penable, pwrite, pready, pslverr, err;
    logic por_ok_in, power_enable_in, term_rail_enable_in, jump;
    logic uv_below_in, uv_recover_in, ov_trip_in, diff_below_in;
    logic ov_code_trip_sel, regulator_ready_o, regulator_ready_oe;
    logic [7:0] paddr, target, voltage_code;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] pwm_in, pwm_o, pwm_oe, low_fet_on;
    logic [8:0] dac_level;
    int failures = 0;
    int n_tests = 0;
    int n;
    vss_sequencer #(.NPHASE(6), .INIT_DELAY_CYC(50), .SW_CYCLE_CYC(12))
    dut_u (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .voltage_code, .por_ok_in,
        .power_enable_in, .term_rail_enable_in, .uv_below_in,
        .uv_recover_in, .ov_trip_in, .diff_below_in, .pwm_in, .pwm_o,
        .pwm_oe, .dac_level, .ov_code_trip_sel, .regulator_ready_o,
        .regulator_ready_oe);
    vss_far_model far_u (.clk_sys, .target, .jump, .voltage_code, .pwm_o,
        .pwm_oe, .low_fet_on);
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi);
        n_tests++;
        if (n < lo || n > hi) begin
            failures++;
            $display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, n);
        end
    endtask
    // Hold the request until pready is seen, released after that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (pready !== 1'b1 && i < 20);
        chk("pready", 1'b1, pready);
        if (pready !== 1'b1) close_out();
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Cycles until dac (0), ready pull-down (1) or low switches (2) show v
    task automatic wait_for(input int sel, input logic [8:0] v, input int lim);
        logic [8:0] s;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
            s = (sel == 0) ? dac_level : {3'h0, low_fet_on};
            if (sel == 1) s = {8'h00, regulator_ready_oe};
        end while (s !== v && n < lim);
        chk("wait", v, s);
        if (s !== v) close_out();
    endtask
    task automatic code_to(input logic [7:0] c);
        @(posedge clk_sys);
        target <= c;
        jump <= 1'b1;
        @(posedge clk_sys);
        jump <= 1'b0;
    endtask
    initial begin
        {reset, jump} = 2'b11;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {por_ok_in, term_rail_enable_in, uv_recover_in} = 3'b111;
        {power_enable_in, uv_below_in, ov_trip_in, diff_below_in} = 4'h0;
        pwm_in = 6'h15;
        target = 8'h50;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        jump <= 1'b0;
        @(negedge clk_sys);
        chk("pins", {6'h00, 2'b10, 9'h000},
            {pwm_oe, regulator_ready_oe, regulator_ready_o, dac_level});
        apb(1'b0, vss_pkg::SS_RATE_OFF, '0);
        chk("rate rst", 32'h64, rd);
        apb(1'b0, 8'h0C, '0);
        chk("unmapped", 32'h0, rd);
        chk("slverr", 1'b1, err);
        apb(1'b1, vss_pkg::STATUS_OFF, 32'hFFFFFFFF);
        apb(1'b0, vss_pkg::STATUS_OFF, '0);
        chk("status", 32'h0, rd);
        apb(1'b1, vss_pkg::SS_RATE_OFF, 32'h5);
        $display("test registers done");
        power_enable_in <= 1'b1;
        wait_for(0, 9'h001, 200);
        chk_rng("delay", 50, 70);
        wait_for(0, 9'h0B0, 2000);
        chk_rng("ramp1", 1398, 1402);
        wait_for(0, 9'h0B1, 4000);
        chk_rng("hold", 3400, 3500);
        wait_for(0, 9'h0B2, 20);
        wait_for(1, 9'h000, 3600);
        chk_rng("ready delay", 3400, 3440);
        chk("run pins", 12'hFD5, {pwm_oe, pwm_o});
        chk("trip sel", 1'b1, ov_code_trip_sel);
        code_to(8'h4F);
        wait_for(0, 9'h0B3, 40);
        chk_rng("code step", 6, 16);
        target <= 8'h4C;
        wait_for(0, 9'h0B6, 300);
        code_to(8'h40);
        wait_for(0, 9'h0C2, 60);
        chk_rng("fast steps", 5, 30);
        code_to(8'h41);
        code_to(8'h40);
        repeat (16) begin
            @(posedge clk_sys);
            chk("abandon", 9'h0C2, dac_level);
        end
        $display("test startup done");
        {uv_below_in, uv_recover_in} <= 2'b10;
        wait_for(1, 9'h001, 10);
        chk_rng("uv", 1, 6);
        uv_below_in <= 1'b0;
        repeat (10) @(posedge clk_sys);
        chk("uv band", 1'b1, regulator_ready_oe);
        uv_recover_in <= 1'b1;
        wait_for(1, 9'h000, 10);
        repeat (2) begin
            ov_trip_in <= 1'b1;
            wait_for(2, 9'h03F, 10);
            chk_rng("ov", 1, 6);
            chk("ov low", 7'h7F, {low_fet_on, regulator_ready_oe});
            {ov_trip_in, diff_below_in} <= 2'b01;
            wait_for(2, 9'h000, 10);
            chk("ov hiz", 6'h00, pwm_oe);
            diff_below_in <= 1'b0;
        end
        code_to(8'h50);
        repeat (40) @(posedge clk_sys);
        chk("latched", 6'h00, pwm_oe);
        power_enable_in <= 1'b0;
        wait_for(0, 9'h000, 10);
        chk("dis ready", 1'b1, regulator_ready_oe);
        $display("test faults done");
        code_to(8'hFF);
        power_enable_in <= 1'b1;
        wait_for(0, 9'h0B0, 2000);
        wait_for(0, 9'h000, 3600);
        apb(1'b0, vss_pkg::STATUS_OFF, '0);
        chk("off", 10'h00F, {pwm_oe, regulator_ready_oe, rd[2:0]});
        power_enable_in <= 1'b0;
        repeat (5) @(posedge clk_sys);
        apb(1'b0, vss_pkg::STATUS_OFF, '0);
        chk("shut", 3'h0, rd[2:0]);
        $display("test off code done");
        close_out();
    end
endmodule
